/* File: mcu_instruction_length_cycle_decoder.v */
// What this block does
// - add_with_carry_op from a working register: one byte, one cycle.
// - subtract_with_borrow_op direct or immediate: two bytes, one cycle.
// - and, or, xor of a working register into accumulator: one byte, one cycle.
// - and, or, xor of a direct byte into accumulator: two bytes, two cycles.
// - and, or, xor of immediate data into accumulator: two bytes, one cycle.
// - and, or, xor of immediate data into a direct byte: three bytes, two cycles.
// - nibble swap of the accumulator: one byte, one cycle.
// - load accumulator with immediate data: two bytes, three cycles.
// - copy accumulator into a working register: one byte, three cycles.
// - load data_pointer with sixteen-bit constant: three bytes, three cycles.
// - code read at A plus data_pointer: one byte, two cycles; PC form one.
// - external reads via data_pointer or eight-bit indirect: one byte, one cycle.
// - external write eight-bit indirect two cycles, data_pointer form one; one byte.
// - stack push and pop of a direct byte: two bytes, two cycles each.
// - low_digit_exchange_op with indirect memory: one byte, two cycles.
// - and complement of direct bit into carry: two bytes, two cycles.
// - or complement of direct bit into carry: two bytes, one cycle.
// - jump_bit_set_and_clear_op branches and clears bit: three bytes, three cycles.
// - jump_bit_clear_op branches on zero bit: three bytes, three cycles.
// - short_relative_jump_op: two bytes, two cycles.
// - compare immediate with accumulator, branch if unequal: three bytes, three cycles.
// - decrement direct byte, branch if nonzero: three bytes, two cycles.
`timescale 1ns/1ps
`include "mcu_dec_map.vh"

module mcu_instruction_length_cycle_decoder (
  input  wire        CLK_I,
  input  wire        ARST_N_I,
  input  wire        FETCH_VALID_I,
  input  wire [7:0]  FETCH_BYTE_I,
  output wire        FETCH_READY_O,
  input  wire        BRANCH_TAKEN_I,
  input  wire [15:0] TARGET_ADDR_I,
  output wire [15:0] PC_O,
  output reg         PC_LOAD_O,
  output reg         EXEC_VALID_O,
  output reg  [7:0]  EXEC_OPCODE_O,
  output reg  [7:0]  EXEC_OPND1_O,
  output reg  [7:0]  EXEC_OPND2_O,
  output reg  [1:0]  EXEC_LEN_O,
  output reg  [3:0]  EXEC_CYCLES_O,
  output reg  [3:0]  EXEC_CLASS_O,
  output wire        EXEC_BUSY_O,
  output reg         INSTR_DONE_O,
  output reg         STACK_PUSH_O,
  output reg  [15:0] RET_ADDR_O,
  output reg         STACK_POP_O,
  output reg         PRIO_RESTORE_O,
  output reg         BIT_CLEAR_O,
  output reg  [7:0]  BIT_ADDR_O
);

  reg  [1:0]  state_ff;
  reg  [1:0]  slot_ff;
  reg  [15:0] pc_ff;
  reg  [1:0]  dec_len;
  reg  [3:0]  dec_cyc;
  reg  [3:0]  dec_cls;
  reg  [1:0]  need_len;
  reg         redirect;
  reg  [15:0] target;
  wire        byte_take;
  wire        last_byte;
  wire        timer_done;
  wire [15:0] pc_seq;
  wire [7:0]  rel_byte;
  wire [15:0] rel_target;

  // length and timing of every opcode; unlisted codes are one byte, one cycle
  always @* begin
    dec_len = `LEN1;
    dec_cyc = `CYC1;
    dec_cls = `CLS_SEQ;
    casez (FETCH_BYTE_I)
      8'h?1: begin
        dec_len = `LEN2;
        dec_cyc = `CYC3;
        dec_cls = FETCH_BYTE_I[4] ? `CLS_ABS_CALL : `CLS_ABS_JMP;
      end
      8'h02: begin dec_len = `LEN3; dec_cyc = `CYC3; dec_cls = `CLS_LONG_JMP;  end
      8'h12: begin dec_len = `LEN3; dec_cyc = `CYC3; dec_cls = `CLS_LONG_CALL; end
      8'h22: begin dec_len = `LEN1; dec_cyc = `CYC3; dec_cls = `CLS_RET;       end
      8'h32: begin dec_len = `LEN1; dec_cyc = `CYC3; dec_cls = `CLS_IRET;      end
      8'h73: begin dec_len = `LEN1; dec_cyc = `CYC2; dec_cls = `CLS_IND_JMP;   end
      // single-operand increment and decrement of a direct byte
      8'h05, 8'h15: begin dec_len = `LEN2; dec_cyc = `CYC2; end
      8'hA3: begin dec_len = `LEN1; dec_cyc = `CYC3; end
      8'hA4: begin dec_len = `LEN1; dec_cyc = `CYC3; end
      8'h84: begin dec_len = `LEN1; dec_cyc = `CYC10; end
      // add and add_with_carry_op
      8'h24, 8'h25, 8'h34, 8'h35: begin dec_len = `LEN2; dec_cyc = `CYC1; end
      8'b0011_1???: begin dec_len = `LEN1; dec_cyc = `CYC1; end
      8'h94, 8'h95: begin dec_len = `LEN2; dec_cyc = `CYC1; end
      // bitwise_or_op, bitwise_and_op, bitwise_xor_op
      8'b0100_1???, 8'b0101_1???, 8'b0110_1???: begin
        dec_len = `LEN1;
        dec_cyc = `CYC1;
      end
      8'h45, 8'h55, 8'h65: begin dec_len = `LEN2; dec_cyc = `CYC2; end
      8'h44, 8'h54, 8'h64: begin dec_len = `LEN2; dec_cyc = `CYC1; end
      8'h43, 8'h53, 8'h63: begin dec_len = `LEN3; dec_cyc = `CYC2; end
      8'h42, 8'h52, 8'h62: begin dec_len = `LEN2; dec_cyc = `CYC2; end
      8'hC4: begin dec_len = `LEN1; dec_cyc = `CYC1; end
      // transfer_op group
      8'h74: begin dec_len = `LEN2; dec_cyc = `CYC3; end
      8'b1111_1???: begin dec_len = `LEN1; dec_cyc = `CYC3; end
      8'hE5: begin dec_len = `LEN2; dec_cyc = `CYC1; end
      8'b1010_1???, 8'b0111_1???, 8'b1000_1???: begin
        dec_len = `LEN2;
        dec_cyc = `CYC2;
      end
      8'h86, 8'h87, 8'h76, 8'h77: begin dec_len = `LEN2; dec_cyc = `CYC2; end
      8'hA6, 8'hA7: begin dec_len = `LEN2; dec_cyc = `CYC3; end
      8'hF5: begin dec_len = `LEN2; dec_cyc = `CYC2; end
      8'hF6, 8'hF7: begin dec_len = `LEN1; dec_cyc = `CYC2; end
      8'h75: begin dec_len = `LEN3; dec_cyc = `CYC2; end
      8'h85: begin dec_len = `LEN3; dec_cyc = `CYC3; end
      8'h90: begin dec_len = `LEN3; dec_cyc = `CYC3; end
      // code_memory_read_op
      8'h93: begin dec_len = `LEN1; dec_cyc = `CYC2; end
      8'h83: begin dec_len = `LEN1; dec_cyc = `CYC1; end
      // external_data_access_op
      8'hE0, 8'hE2, 8'hE3: begin dec_len = `LEN1; dec_cyc = `CYC1; end
      8'hF2, 8'hF3: begin dec_len = `LEN1; dec_cyc = `CYC2; end
      8'hF0: begin dec_len = `LEN1; dec_cyc = `CYC1; end
      8'hC0, 8'hD0: begin dec_len = `LEN2; dec_cyc = `CYC2; end
      // exchanges
      8'hC5: begin dec_len = `LEN2; dec_cyc = `CYC2; end
      8'hC6, 8'hC7, 8'b1100_1???: begin dec_len = `LEN1; dec_cyc = `CYC2; end
      8'hD6, 8'hD7: begin dec_len = `LEN1; dec_cyc = `CYC2; end
      // carry and bit operations
      8'h82: begin dec_len = `LEN2; dec_cyc = `CYC2; end
      8'hB0: begin dec_len = `LEN2; dec_cyc = `CYC2; end
      8'hA0: begin dec_len = `LEN2; dec_cyc = `CYC1; end
      8'h72, 8'hA2, 8'h92, 8'hB2, 8'hC2, 8'hD2: begin
        dec_len = `LEN2;
        dec_cyc = `CYC1;
      end
      // conditional and relative branches
      8'h10: begin dec_len = `LEN3; dec_cyc = `CYC3; dec_cls = `CLS_BIT_CLR; end
      8'h30: begin dec_len = `LEN3; dec_cyc = `CYC3; dec_cls = `CLS_REL_COND; end
      8'h20: begin dec_len = `LEN3; dec_cyc = `CYC2; dec_cls = `CLS_REL_COND; end
      8'h80: begin dec_len = `LEN2; dec_cyc = `CYC2; dec_cls = `CLS_REL_JMP; end
      8'h40, 8'h50, 8'h60, 8'h70, 8'b1101_1???: begin
        dec_len = `LEN2;
        dec_cyc = `CYC2;
        dec_cls = `CLS_REL_COND;
      end
      8'hB4: begin dec_len = `LEN3; dec_cyc = `CYC3; dec_cls = `CLS_REL_COND; end
      8'hB5, 8'hB6, 8'hB7, 8'b1011_1???: begin
        dec_len = `LEN3;
        dec_cyc = `CYC3;
        dec_cls = `CLS_REL_COND;
      end
      8'hD5: begin dec_len = `LEN3; dec_cyc = `CYC2; dec_cls = `CLS_REL_COND; end
      // add of a register or indirect byte
      8'b0010_1???, 8'h26, 8'h27: begin
        dec_len = `LEN1;
        dec_cyc = `CYC1;
      end
      // carry and borrow forms on indirect bytes, borrow form on registers
      8'h36, 8'h37, 8'b1001_1???, 8'h96, 8'h97: begin
        dec_len = `LEN1;
        dec_cyc = `CYC1;
      end
      // single-byte increment and decrement
      8'h04, 8'h06, 8'h07, 8'b0000_1???, 8'h14, 8'h16, 8'h17, 8'b0001_1???: begin
        dec_len = `LEN1;
        dec_cyc = `CYC1;
      end
      // logic on an indirect byte into the accumulator
      8'h46, 8'h47, 8'h56, 8'h57, 8'h66, 8'h67: begin
        dec_len = `LEN1;
        dec_cyc = `CYC1;
      end
      // accumulator clear, complement, rotates and decimal adjust
      8'hE4, 8'hF4, 8'h03, 8'h13, 8'h23, 8'h33, 8'hD4: begin
        dec_len = `LEN1;
        dec_cyc = `CYC1;
      end
      // transfer_op into the accumulator from a register or indirect byte
      8'b1110_1???, 8'hE6, 8'hE7: begin
        dec_len = `LEN1;
        dec_cyc = `CYC1;
      end
      // carry flag forms, no operation, and the reserved code
      8'hC3, 8'hD3, 8'hB3, 8'h00, 8'hA5: begin
        dec_len = `LEN1;
        dec_cyc = `CYC1;
      end
      default: begin
        dec_len = `LEN1;
        dec_cyc = `CYC1;
        dec_cls = `CLS_SEQ;
      end
    endcase
  end

  // fetch side: bytes are refused while an instruction executes
  assign FETCH_READY_O = (state_ff == `ST_FETCH);
  assign byte_take     = FETCH_VALID_I && FETCH_READY_O;
  assign last_byte     = (slot_ff == `SLOT_OP) ? (dec_len == `LEN1)
                                               : (slot_ff == (need_len - 2'h1));
  assign PC_O          = pc_ff;

  // relative offset is always the final byte of its instruction
  assign pc_seq     = pc_ff + {14'h0000, EXEC_LEN_O};
  assign rel_byte   = (EXEC_LEN_O == `LEN2) ? EXEC_OPND1_O : EXEC_OPND2_O;
  assign rel_target = pc_seq + {{8{rel_byte[`SIGN_BIT]}}, rel_byte};

  // where control goes when the instruction ends
  always @* begin
    redirect = 1'b0;
    target   = pc_seq;
    case (EXEC_CLASS_O)
      `CLS_REL_JMP: begin
        redirect = 1'b1;
        target   = rel_target;
      end
      `CLS_REL_COND, `CLS_BIT_CLR: begin
        redirect = BRANCH_TAKEN_I;
        target   = rel_target;
      end
      `CLS_ABS_JMP, `CLS_ABS_CALL: begin
        redirect = 1'b1;
        target   = {pc_seq[`PC_PAGE], EXEC_OPCODE_O[`OP_PAGE], EXEC_OPND1_O};
      end
      `CLS_LONG_JMP, `CLS_LONG_CALL: begin
        redirect = 1'b1;
        target   = {EXEC_OPND1_O, EXEC_OPND2_O};
      end
      `CLS_RET, `CLS_IRET, `CLS_IND_JMP: begin
        redirect = 1'b1;
        target   = TARGET_ADDR_I;
      end
      default: begin
        redirect = 1'b0;
        target   = pc_seq;
      end
    endcase
  end

  always @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_ff       <= `ST_FETCH;
      slot_ff        <= `SLOT_OP;
      need_len       <= `LEN1;
      pc_ff          <= `PC_RST;
      PC_LOAD_O      <= 1'b0;
      EXEC_VALID_O   <= 1'b0;
      EXEC_OPCODE_O  <= `BYTE_ZERO;
      EXEC_OPND1_O   <= `BYTE_ZERO;
      EXEC_OPND2_O   <= `BYTE_ZERO;
      EXEC_LEN_O     <= `LEN1;
      EXEC_CYCLES_O  <= `CYC1;
      EXEC_CLASS_O   <= `CLS_SEQ;
      INSTR_DONE_O   <= 1'b0;
      STACK_PUSH_O   <= 1'b0;
      RET_ADDR_O     <= `PC_RST;
      STACK_POP_O    <= 1'b0;
      PRIO_RESTORE_O <= 1'b0;
      BIT_CLEAR_O    <= 1'b0;
      BIT_ADDR_O     <= `BYTE_ZERO;
    end else begin
      PC_LOAD_O      <= 1'b0;
      EXEC_VALID_O   <= 1'b0;
      INSTR_DONE_O   <= 1'b0;
      STACK_PUSH_O   <= 1'b0;
      STACK_POP_O    <= 1'b0;
      PRIO_RESTORE_O <= 1'b0;
      BIT_CLEAR_O    <= 1'b0;
      case (state_ff)
        `ST_FETCH: begin
          if (byte_take) begin
            if (slot_ff == `SLOT_OP) begin
              EXEC_OPCODE_O <= FETCH_BYTE_I;
              EXEC_OPND1_O  <= `BYTE_ZERO;
              EXEC_OPND2_O  <= `BYTE_ZERO;
              EXEC_LEN_O    <= dec_len;
              EXEC_CYCLES_O <= dec_cyc;
              EXEC_CLASS_O  <= dec_cls;
              need_len      <= dec_len;
            end else if (slot_ff == `SLOT_B1) begin
              EXEC_OPND1_O <= FETCH_BYTE_I;
            end else begin
              EXEC_OPND2_O <= FETCH_BYTE_I;
            end
            if (last_byte) begin
              slot_ff      <= `SLOT_OP;
              state_ff     <= `ST_EXEC;
              EXEC_VALID_O <= 1'b1;
              // pop is requested at issue so the address is back by the end
              if ((slot_ff == `SLOT_OP) &&
                  ((dec_cls == `CLS_RET) || (dec_cls == `CLS_IRET))) begin
                STACK_POP_O <= 1'b1;
              end
            end else begin
              slot_ff <= slot_ff + 2'h1;
            end
          end
        end
        `ST_EXEC: begin
          if (timer_done) begin
            state_ff     <= `ST_FETCH;
            INSTR_DONE_O <= 1'b1;
            pc_ff        <= redirect ? target : pc_seq;
            PC_LOAD_O    <= redirect;
            if ((EXEC_CLASS_O == `CLS_ABS_CALL) || (EXEC_CLASS_O == `CLS_LONG_CALL)) begin
              STACK_PUSH_O <= 1'b1;
              RET_ADDR_O   <= pc_seq;
            end
            if (EXEC_CLASS_O == `CLS_IRET) begin
              PRIO_RESTORE_O <= 1'b1;
            end
            // the tested bit is cleared only on a taken branch
            if ((EXEC_CLASS_O == `CLS_BIT_CLR) && BRANCH_TAKEN_I) begin
              BIT_CLEAR_O <= 1'b1;
              BIT_ADDR_O  <= EXEC_OPND1_O;
            end
          end
        end
        default: begin
          state_ff <= `ST_FETCH;
          slot_ff  <= `SLOT_OP;
        end
      endcase
    end
  end

  // execution time is counted in machine cycles from the issue pulse
  mcu_cycle_timer u_timer (
    .clk_i    (CLK_I),
    .arst_n_i (ARST_N_I),
    .start_i  (EXEC_VALID_O),
    .cycles_i (EXEC_CYCLES_O),
    .busy_o   (EXEC_BUSY_O),
    .done_o   (timer_done)
  );

endmodule // mcu_instruction_length_cycle_decoder

/* File: mcu_dec_map.vh */
`ifndef MCU_DEC_MAP_VH
`define MCU_DEC_MAP_VH

// encoded lengths in bytes
`define LEN1 2'h1
`define LEN2 2'h2
`define LEN3 2'h3

// execution times in machine cycles
`define CYC1  4'h1
`define CYC2  4'h2
`define CYC3  4'h3
`define CYC10 4'hA

// control-flow classes
`define CLS_SEQ       4'h0
`define CLS_REL_COND  4'h1
`define CLS_REL_JMP   4'h2
`define CLS_ABS_JMP   4'h3
`define CLS_LONG_JMP  4'h4
`define CLS_ABS_CALL  4'h5
`define CLS_LONG_CALL 4'h6
`define CLS_RET       4'h7
`define CLS_IRET      4'h8
`define CLS_IND_JMP   4'h9
`define CLS_BIT_CLR   4'hA

// sequencing states
`define ST_FETCH 2'h0
`define ST_EXEC  2'h1

// byte slots within one instruction
`define SLOT_OP  2'h0
`define SLOT_B1  2'h1

// clocks per machine cycle
`define MCYC_CLKS 4'h1
`define CNT_ZERO  4'h0

// address fields
`define PC_RST     16'h0000
`define PC_PAGE    15:11
`define OP_PAGE    7:5
`define SIGN_BIT   7
`define BYTE_ZERO  8'h00

`endif

/* File: mcu_cycle_timer.v */
`timescale 1ns/1ps
`include "mcu_dec_map.vh"

module mcu_cycle_timer (
  input  wire       clk_i,
  input  wire       arst_n_i,
  input  wire       start_i,
  input  wire [3:0] cycles_i,
  output wire       busy_o,
  output reg        done_o
);

  reg  [3:0] div_ff;
  reg  [3:0] rem_ff;
  reg        busy_ff;
  wire       tick;

  // machine-cycle enable; restarts with each instruction so counts align
  assign tick   = busy_ff && (div_ff == (`MCYC_CLKS - 4'h1));
  assign busy_o = busy_ff;

  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_ff  <= `CNT_ZERO;
      rem_ff  <= `CNT_ZERO;
      busy_ff <= 1'b0;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        div_ff  <= 4'h0;
        rem_ff  <= cycles_i;
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        div_ff <= tick ? 4'h0 : div_ff + 4'h1;
        if (tick) begin
          rem_ff <= rem_ff - 4'h1;
          if (rem_ff == 4'h1) begin
            busy_ff <= 1'b0;
            done_o  <= 1'b1;
          end
        end
      end
    end
  end

endmodule // mcu_cycle_timer

/* File: mcu_decoder_asserts.sv */
`timescale 1ns/1ps
module mcu_decoder_asserts (
  input wire logic       CLK_I,
  input wire logic       ARST_N_I,
  input wire logic       FETCH_VALID_I,
  input wire logic       FETCH_READY_O,
  input wire logic       EXEC_VALID_O,
  input wire logic [7:0] EXEC_OPCODE_O,
  input wire logic [7:0] EXEC_OPND1_O,
  input wire logic [1:0] EXEC_LEN_O,
  input wire logic [3:0] EXEC_CYCLES_O,
  input wire logic [3:0] EXEC_CLASS_O,
  input wire logic       EXEC_BUSY_O,
  input wire logic       INSTR_DONE_O,
  input wire logic       PC_LOAD_O,
  input wire logic       STACK_PUSH_O,
  input wire logic       STACK_POP_O,
  input wire logic       PRIO_RESTORE_O,
  input wire logic       BIT_CLEAR_O,
  input wire logic [7:0] BIT_ADDR_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  // machine cycles left of the issued instruction, one clock each;
  // the end pulse trails the last counted cycle by two clocks of registering
  logic [3:0] cnt_ff;
  always_ff @(posedge CLK_I or negedge ARST_N_I)
    if (!ARST_N_I) cnt_ff <= 4'h0;
    else if (EXEC_VALID_O) cnt_ff <= EXEC_CYCLES_O;
    else if (cnt_ff != 4'h0) cnt_ff <= cnt_ff - 4'h1;
  a_done_on_time: assert property (cnt_ff == 4'h1 |-> ##2 INSTR_DONE_O)
    else $error("completion late");
  a_done_has_cause: assert property (INSTR_DONE_O |-> $past(cnt_ff, 2) == 4'h1)
    else $error("completion early");
  a_issue_after_fetch: assert property (EXEC_VALID_O
    |-> $past(FETCH_VALID_I & FETCH_READY_O))
    else $error("issue without byte");
  a_refuse_busy: assert property (EXEC_BUSY_O |-> !FETCH_READY_O)
    else $error("ready while busy");
  a_pop_at_issue: assert property (STACK_POP_O |-> EXEC_VALID_O
    && EXEC_OPCODE_O inside {8'h22, 8'h32})
    else $error("stray pop");
  a_push_redirects: assert property (STACK_PUSH_O |-> INSTR_DONE_O && PC_LOAD_O)
    else $error("push without redirect");
  a_prio_on_iret: assert property (PRIO_RESTORE_O |-> INSTR_DONE_O
    && EXEC_OPCODE_O == 8'h32)
    else $error("stray priority restore");
  a_clear_on_jbc: assert property (BIT_CLEAR_O |-> INSTR_DONE_O && EXEC_OPCODE_O == 8'h10
    && BIT_ADDR_O == EXEC_OPND1_O)
    else $error("bad bit clear");
  a_short_jump: assert property (INSTR_DONE_O && EXEC_OPCODE_O == 8'h80 |-> PC_LOAD_O)
    else $error("short jump not taken");
  a_short_class: assert property (EXEC_VALID_O && EXEC_OPCODE_O == 8'h80
    |-> EXEC_CLASS_O == 4'h2)
    else $error("short jump class wrong");
  a_decrement_branch_nonzero_op_form: assert property (EXEC_VALID_O && EXEC_OPCODE_O == 8'hD5
    |-> EXEC_LEN_O == 2'h3 && EXEC_CYCLES_O == 4'h2)
    else $error("decrement branch form wrong");
  a_load_at_end: assert property (PC_LOAD_O |-> INSTR_DONE_O)
    else $error("redirect off end");
endmodule // mcu_decoder_asserts

/* File: fetch_feeder.sv */
`timescale 1ns/1ps
module fetch_feeder (
  input  wire logic  clk_i,
  input  wire logic  rdy_i,
  output logic       valid_o,
  output logic [7:0] byte_o,
  output logic       taken_o,
  output logic [15:0] target_o
);
  initial begin
    valid_o = 1'b0;
    byte_o = 8'h5A;
    taken_o = 1'b0;
    target_o = 16'h0000;
  end
  // held until the next instruction is sent, so in held runs valid when the end samples it
  task automatic set_branch(input logic tk, input logic [15:0] tg);
    taken_o = tk;
    target_o = tg;
  endtask
  task automatic send(input logic [7:0] b0, b1, b2, input logic [1:0] n);
    logic [23:0] w;
    w = {b0, b1, b2};
    for (int i = 0; i < n; i++) begin
      valid_o = 1'b1;
      byte_o = w[23:16];
      w = w << 8;
      while (rdy_i !== 1'b1) begin
        @(posedge clk_i);
        #1;
      end
      @(posedge clk_i);
      #1;
    end
  endtask
  task automatic idle();
    valid_o = 1'b0;
    byte_o = ~byte_o; // released bus shows no stale byte
  endtask
endmodule // fetch_feeder

/* File: mcu_instruction_length_cycle_decoder_tb.sv */
`timescale 1ns/1ps
module mcu_instruction_length_cycle_decoder_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        valid, ready, taken, ld, ev, done, push, pop, prio, bclr;
  logic [7:0]  fb, op, o1, o2, baddr;
  logic [15:0] tgt, pc, ret, pc_m;
  logic [1:0]  len;
  logic [3:0]  cyc;
  logic [30:0] iq [$];
  logic [43:0] dq [$];
  int          num_errors = 0;
  int          n_checks = 0;
  int          lat = 0;
  logic [3:0]  lc = 4'h0;
  logic [15:0] tbl [0:44] = '{
    16'h3811, 16'h3F11, 16'h9521, 16'h9421,
    16'h5811, 16'h4811, 16'h6F11, 16'h5522, 16'h4522, 16'h6522,
    16'h5421, 16'h4421, 16'h6421, 16'h5332, 16'h4332, 16'h6332,
    16'hC411, 16'h7423, 16'hF813, 16'hFF13, 16'h9033,
    16'h9312, 16'h8311, 16'hE011, 16'hE211, 16'hF212, 16'hF011,
    16'hC022, 16'hD022, 16'hD612, 16'hB022, 16'hA021,
    16'h1033, 16'h3033, 16'h8022, 16'hB433, 16'hD532,
    16'h1233, 16'h2213, 16'h3213,
    16'h0123, 16'h1123, 16'h0233, 16'h7312, 16'h4022};
  fetch_feeder fetch_feeder_inst (.clk_i(clk), .rdy_i(ready), .valid_o(valid), .byte_o(fb),
    .taken_o(taken), .target_o(tgt));
  mcu_instruction_length_cycle_decoder mcu_instruction_length_cycle_decoder_inst (
    .CLK_I(clk), .ARST_N_I(rst_n), .FETCH_VALID_I(valid), .FETCH_BYTE_I(fb),
    .FETCH_READY_O(ready), .BRANCH_TAKEN_I(taken), .TARGET_ADDR_I(tgt), .PC_O(pc),
    .PC_LOAD_O(ld), .EXEC_VALID_O(ev), .EXEC_OPCODE_O(op), .EXEC_OPND1_O(o1),
    .EXEC_OPND2_O(o2), .EXEC_LEN_O(len), .EXEC_CYCLES_O(cyc), .EXEC_CLASS_O(),
    .EXEC_BUSY_O(), .INSTR_DONE_O(done), .STACK_PUSH_O(push), .RET_ADDR_O(ret),
    .STACK_POP_O(pop), .PRIO_RESTORE_O(prio), .BIT_CLEAR_O(bclr), .BIT_ADDR_O(baddr));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (done !== 1'b1 && k < 40);
    if (k >= 40) check(16'h0000, 16'h0001);
  endtask
  task automatic instr(input logic [15:0] row, input logic tk, input logic hold);
    logic [7:0]  c, b1, b2, rel;
    logic [1:0]  n;
    logic [15:0] nxt, np, tg;
    logic        jmp, ps, pp, ab, lg;
    c = row[15:8];
    n = row[5:4];
    b1 = (n > 2'h1) ? 8'($urandom) : 8'h00;
    b2 = (n > 2'h2) ? 8'($urandom) : 8'h00;
    rel = (n == 2'h3) ? b2 : b1;
    tg = 16'($urandom);
    nxt = pc_m + 16'(n);
    ab = (c[3:0] == 4'h1);
    lg = (c == 8'h12) || (c == 8'h02);
    ps = (c == 8'h12) || (ab && c[4]);
    pp = (c == 8'h22) || (c == 8'h32);
    jmp = ab || lg || pp || c inside {8'h73, 8'h80}
          || (tk && c inside {8'h10, 8'h30, 8'h40, 8'hB4, 8'hD5});
    np = !jmp ? nxt : ab ? {nxt[15:11], c[7:5], b1} : lg ? {b1, b2}
       : (pp || c == 8'h73) ? tg : nxt + {{8{rel[7]}}, rel};
    iq.push_back({c, b1, b2, n, row[3:0], pp});
    dq.push_back({np, jmp, ps, c == 8'h32, jmp && c == 8'h10, nxt, b1});
    pc_m = np;
    fetch_feeder_inst.set_branch(tk, tg);
    fetch_feeder_inst.send(c, b1, b2, n);
    if (hold) begin
      fetch_feeder_inst.idle();
      wait_done();
    end
  endtask
  // issue and end notes are taken off in the order the driver queued them
  always @(negedge clk) begin
    logic [30:0] e;
    logic [43:0] d;
    if (rst_n) begin
      lat++;
      if (ev === 1'b1) begin
        e = iq.pop_front();
        lat = 0;
        lc = e[4:1];
        check(op, e[30:23]);
        check(o1, e[22:15]);
        check(o2, e[14:7]);
        check(len, e[6:5]);
        check(cyc, e[4:1]);
        check(pop, e[0]);
      end else check(pop, 1'b0);
      if (done === 1'b1) begin
        d = dq.pop_front();
        // end pulse lands two clocks after the last counted machine cycle
        check(16'(lat), 16'(lc) + 16'h0002);
        check(pc, d[43:28]);
        check(ld, d[27]);
        check(push, d[26]);
        check(prio, d[25]);
        check(bclr, d[24]);
        if (d[26]) check(ret, d[23:8]);
        if (d[24]) check(baddr, d[7:0]);
      end else check({ld, push, prio, bclr}, 4'h0);
    end
  end
  initial begin
    #100000;
    check(16'h0000, 16'h0001);
    wrap_up();
  end
  initial begin
    pc_m = 16'h0000;
    void'($urandom(96));
    do_reset();
    for (int p = 0; p < 2; p++)
      foreach (tbl[i]) instr(tbl[i], p[0], 1'b1);
    // back to back: next opcode waits on the bus while the last one runs
    for (int i = 0; i < 32; i++) instr(tbl[i], 1'b0, 1'b0);
    fetch_feeder_inst.idle();
    wait_done();
    instr(tbl[17], 1'b0, 1'b0);
    fetch_feeder_inst.idle();
    @(posedge clk);
    #1;
    iq.delete();
    dq.delete();
    do_reset();
    pc_m = 16'h0000;
    check(pc, 16'h0000);
    check({ready, len, cyc}, {1'b1, 2'h1, 4'h1});
    instr(tbl[33], 1'b1, 1'b1);
    wrap_up();
  end
endmodule // mcu_instruction_length_cycle_decoder_tb
bind mcu_instruction_length_cycle_decoder mcu_decoder_asserts mcu_decoder_asserts_inst (
  .CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .FETCH_VALID_I(FETCH_VALID_I),
  .FETCH_READY_O(FETCH_READY_O), .EXEC_VALID_O(EXEC_VALID_O), .EXEC_OPCODE_O(EXEC_OPCODE_O),
  .EXEC_OPND1_O(EXEC_OPND1_O), .EXEC_LEN_O(EXEC_LEN_O), .EXEC_CYCLES_O(EXEC_CYCLES_O),
  .EXEC_CLASS_O(EXEC_CLASS_O), .EXEC_BUSY_O(EXEC_BUSY_O), .INSTR_DONE_O(INSTR_DONE_O),
  .PC_LOAD_O(PC_LOAD_O), .STACK_PUSH_O(STACK_PUSH_O), .STACK_POP_O(STACK_POP_O),
  .PRIO_RESTORE_O(PRIO_RESTORE_O), .BIT_CLEAR_O(BIT_CLEAR_O), .BIT_ADDR_O(BIT_ADDR_O));
